// ==== hw/hr_record_if.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "hr_cfg.svh"

// Function
// - directory gives revision 2.0, one client, four channels, feature 149
// - directory lists settings 131+n and request 80+2n per channel
// - directory reports write-to-read offset of one
// - feature byte 0 is 0x62, byte 1 is zero
// - feature byte 2 gives 240 as longest request
// - sixteen polled variables readable in record 121
// - each variable is 4 value bytes then quality, 20 per channel
// - disabled channel or missing variable reads zero with quality 0x37
// - records 131 to 134 hold per-channel settings
// - parameter reassignment reloads settings from initial values
// - settings writes ignored while field supply is absent
// - settings preamble 255 means 20 preamble bytes
// - settings preamble 0 means device need, at least 5
// - request/response records 80/81 to 86/87 per channel
// - request control reserved bits zero; bits 5, 6 select options, bit 2 unused
// - request preamble 255 takes the settings value, default five
// - compact or transparent accepted, response always transparent
// - active shorthand sequence on one channel holds others back
// - response control bits 0-2 carry processing result
// - invalid settings preamble written is discarded, old value kept
module hr_record_if (
  input  wire logic        core_clk,        // 100 MHz clock
  input  wire logic        rst,             // sync reset, high
  input  wire logic        ce,              // clock enable
  input  wire logic [15:0] addr,            // record and byte
  input  wire logic [7:0]  wdata,           // write byte
  input  wire logic        wr,              // write strobe
  input  wire logic        rd,              // read strobe
  output logic      [7:0]  rdata,           // read byte
  input  wire logic [3:0]  hart_en,         // hart on per channel
  input  wire logic        supply_ok,       // field supply present
  input  wire logic        param_reassign,  // reload pulse
  input  wire logic [31:0] init_preamble,   // initial settings
  input  wire logic [31:0] dev_preamble,    // device need per ch
  input  wire logic        var_we,          // variable update
  input  wire logic [1:0]  var_ch,          // its channel
  input  wire logic [1:0]  var_idx,         // primary..quaternary
  input  wire logic [31:0] var_value,       // real value
  input  wire logic [7:0]  var_quality,     // quality code
  input  wire logic        var_supplied,    // device gives it
  output logic             fd_start,        // request launch
  output logic      [1:0]  fd_ch,           // launched channel
  output logic      [7:0]  fd_preamble,     // preamble count
  output logic             fd_compact,      // compact format
  output logic             fd_seq_mode,     // shorthand mode
  output logic      [7:0]  fd_len,          // request length
  input  wire logic [7:0]  fd_rd_addr,      // request byte addr
  output logic      [7:0]  fd_rd_data,      // request byte
  input  wire logic        fd_rsp_we,       // response byte write
  input  wire logic [7:0]  fd_rsp_addr,     // its offset
  input  wire logic [7:0]  fd_rsp_data,     // its value
  input  wire logic        fd_done,         // reply or timeout
  input  wire logic [2:0]  fd_result        // result code
);
  hr_pkg::hr_state_s r;
  hr_pkg::hr_state_s n;

  logic [7:0]  req_mem [0:3][0:239];
  logic [7:0]  rsp_mem [0:3][0:239];
  logic [31:0] var_val [0:15];
  logic [7:0]  var_q   [0:15];
  logic [15:0] var_sup;

  logic [7:0]  rec;
  logic [7:0]  off;
  logic [1:0]  rch;
  logic [1:0]  sch;
  logic        w_req;
  logic        w_set;
  logic        blk;
  logic [7:0]  rd_val;
  logic [3:0]  vidx;
  logic [2:0]  bi;
  logic        vok;
  logic [7:0]  rp;

  assign rec = addr[15:8];
  assign off = addr[7:0];
  assign rch = rec[2:1];
  assign sch = 2'(rec - `HR_REC_SET0);
  assign w_req = wr && rec >= `HR_REC_REQ0 && rec <= `HR_REC_RSP3
                 && !rec[0] && off < `HR_LEN_REC
                 && (r.st[rch] == hr_pkg::HR_IDLE
                     || r.st[rch] == hr_pkg::HR_DONE);
  assign w_set = wr && rec >= `HR_REC_SET0 && rec <= `HR_REC_SET3
                 && off < `HR_LEN_SET;
  assign rp = req_mem[rch][1];

  function automatic logic [7:0] eff_pre(input logic [7:0] s,
                                         input logic [7:0] m);
    if (s == `HR_PRE_CFG) eff_pre = `HR_PRE_MAX;
    else if (s == `HR_PRE_AUTO)
      eff_pre = (m < `HR_PRE_MIN) ? `HR_PRE_MIN : m;
    else eff_pre = s;
  endfunction : eff_pre

  function automatic logic pre_ok(input logic [7:0] p);
    pre_ok = p == `HR_PRE_CFG
             || (p >= `HR_PRE_MIN && p <= `HR_PRE_MAX);
  endfunction : pre_ok

  // ==========================================
  // read multiplexer
  always_comb begin
    rd_val = 8'h00;
    vidx = 4'(off / 8'd5);
    bi = 3'(off - 8'(vidx) * 8'd5);
    vok = hart_en[vidx[3:2]] && var_sup[vidx];
    if (rec == `HR_REC_DIR && off < `HR_LEN_DIR) begin
      case (off)
        8'h00: rd_val = `HR_REV_MAJ;
        8'h01: rd_val = `HR_REV_MIN;
        8'h02: rd_val = `HR_UNUSED;
        8'h03: rd_val = `HR_CLIENTS;
        8'h04: rd_val = `HR_CHANNELS;
        8'h05: rd_val = `HR_WR_OFS;
        8'h06: rd_val = `HR_REC_FEAT;
        8'h07: rd_val = `HR_UNUSED;
        8'h08: rd_val = `HR_UNUSED;
        default: rd_val = (off < `HR_DIR_REQ)
          ? 8'(`HR_REC_SET0 + off - `HR_DIR_SET)
          : 8'(`HR_REC_REQ0 + 8'((off - `HR_DIR_REQ) << 1));
      endcase
    end else if (rec == `HR_REC_FEAT && off < `HR_LEN_FEAT) begin
      case (off)
        8'h00:   rd_val = `HR_FEAT0;
        8'h01:   rd_val = `HR_FEAT1;
        default: rd_val = `HR_LEN_REC;
      endcase
    end else if (rec == `HR_REC_VAR && off < `HR_LEN_VAR) begin
      case (bi)
        3'h0:    rd_val = vok ? var_val[vidx][31:24] : 8'h00;
        3'h1:    rd_val = vok ? var_val[vidx][23:16] : 8'h00;
        3'h2:    rd_val = vok ? var_val[vidx][15:8] : 8'h00;
        3'h3:    rd_val = vok ? var_val[vidx][7:0] : 8'h00;
        default: rd_val = vok ? var_q[vidx] : `HR_QUAL_NONE;
      endcase
    end else if (rec >= `HR_REC_SET0 && rec <= `HR_REC_SET3
                 && off < `HR_LEN_SET) begin
      rd_val = r.set[sch][off[2:0]];
    end else if (rec >= `HR_REC_REQ0 && rec <= `HR_REC_RSP3
                 && off < `HR_LEN_REC) begin
      if (rec[0] && off == 8'h00)
        rd_val = {1'b0, r.seq_mode[rch], 3'b000, r.res[rch]};
      else if (rec[0]) rd_val = rsp_mem[rch][off];
      else rd_val = req_mem[rch][off];
    end
  end

  // ==========================================
  // next state
  always_comb begin
    n = r;
    n.start = 1'b0;
    blk = 1'b0;
    if (rd) n.rdata = rd_val;
    if (w_set && supply_ok && (off != 8'h00 || wdata == 8'h00
                               || pre_ok(wdata)))
      n.set[sch][off[2:0]] = wdata;
    if (w_req && off != 8'h00 && off >= r.len[rch])
      n.len[rch] = 8'(off + 8'h01);
    if (w_req && off == 8'h00) begin
      n.ctrl[rch] = wdata;
      if ((wdata & `HR_CTRL_RSVD) != 8'h00 || !pre_ok(rp)
          || !hart_en[rch]) begin
        n.st[rch] = hr_pkg::HR_DONE;
        n.res[rch] = `HR_RES_ERR;
      end else begin
        n.st[rch] = hr_pkg::HR_WAIT;
        n.res[rch] = `HR_RES_WAIT;
        n.seq_mode[rch] = wdata[`HR_CTRL_SEQ];
        n.pre[rch] = (rp == `HR_PRE_CFG)
          ? eff_pre(r.set[rch][0], dev_preamble[8*rch +: 8]) : rp;
      end
    end
    if (r.busy && fd_done) begin
      n.st[r.cur] = hr_pkg::HR_DONE;
      n.res[r.cur] = fd_result;
      n.len[r.cur] = 8'h00;
      n.busy = 1'b0;
    end else if (!r.busy) begin
      for (int c = 0; c < 4; c++) begin
        if (!blk && r.st[c] == hr_pkg::HR_WAIT && hart_en[c]
            && (r.seq_mode & ~(4'h1 << c)) == 4'h0) begin
          blk = 1'b1;
          n.st[c] = hr_pkg::HR_EXEC;
          n.res[c] = `HR_RES_EXEC;
          n.busy = 1'b1;
          n.cur = 2'(c);
          n.start = 1'b1;
          n.fd_pre = r.pre[c];
          n.cmp = r.ctrl[c][`HR_CTRL_CMP];
          n.fd_seq = r.ctrl[c][`HR_CTRL_SEQ];
          n.fd_len = r.len[c];
        end
      end
    end
    if (param_reassign) begin
      for (int c = 0; c < 4; c++) begin
        n.set[c] = '0;
        n.set[c][0] = init_preamble[8*c +: 8];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      r <= '0;
      for (int c = 0; c < 4; c++) begin
        r.st[c] <= hr_pkg::HR_IDLE;
        r.res[c] <= `HR_RES_IDLE;
        r.set[c][0] <= `HR_PRE_DFLT;
      end
    end else if (ce) begin
      r <= n;
    end
  end

  // ==========================================
  // record memories
  always_ff @(posedge core_clk) begin
    if (rst) begin
      var_sup <= 16'h0000;
      fd_rd_data <= 8'h00;
    end else if (ce) begin
      if (w_req) req_mem[rch][off] <= wdata;
      if (fd_rsp_we && r.busy && fd_rsp_addr != 8'h00
          && fd_rsp_addr < `HR_LEN_REC)
        rsp_mem[r.cur][fd_rsp_addr] <= fd_rsp_data;
      if (var_we) begin
        var_val[{var_ch, var_idx}] <= var_value;
        var_q[{var_ch, var_idx}] <= var_quality;
        var_sup[{var_ch, var_idx}] <= var_supplied;
      end
      fd_rd_data <= req_mem[r.cur][fd_rd_addr];
    end
  end

  assign rdata = r.rdata;
  assign fd_start = r.start;
  assign fd_ch = r.cur;
  assign fd_preamble = r.fd_pre;
  assign fd_compact = r.cmp;
  assign fd_seq_mode = r.fd_seq;
  assign fd_len = r.fd_len;

  // ==========================================
  // assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_rd(logic [15:0] a);
    ce && rd && addr == a;
  endsequence

  property p_dir_rev;
    s_rd({`HR_REC_DIR, 8'h00}) |=> rdata == 8'h02;
  endproperty
  a_dir_rev: assert property (p_dir_rev)
    else $error("directory revision wrong");

  property p_dir_req;
    s_rd({`HR_REC_DIR, 8'h10}) |=> rdata == 8'h56;
  endproperty
  a_dir_req: assert property (p_dir_req)
    else $error("channel 3 request index wrong");

  property p_dir_ofs;
    s_rd({`HR_REC_DIR, 8'h05}) |=> rdata == 8'h01;
  endproperty
  a_dir_ofs: assert property (p_dir_ofs)
    else $error("index offset wrong");

  property p_feat;
    s_rd({`HR_REC_FEAT, 8'h00}) |=> rdata == 8'h62;
  endproperty
  a_feat: assert property (p_feat)
    else $error("feature byte wrong");

  property p_maxlen;
    s_rd({`HR_REC_FEAT, 8'h02}) |=> rdata == 8'hf0;
  endproperty
  a_maxlen: assert property (p_maxlen)
    else $error("max length wrong");

  property p_quality;
    s_rd({`HR_REC_VAR, 8'h22}) ##0 !hart_en[1] |=> rdata == 8'h37;
  endproperty
  a_quality: assert property (p_quality)
    else $error("quality code for disabled channel wrong");

  property p_supply;
    ce && w_set && sch == 2'h0 && !supply_ok && !param_reassign
      |=> $stable(r.set[0]);
  endproperty
  a_supply: assert property (p_supply)
    else $error("settings taken without supply");

  property p_reassign;
    ce && param_reassign |=> r.set[1][0] == $past(init_preamble[15:8]);
  endproperty
  a_reassign: assert property (p_reassign)
    else $error("settings not reloaded");

  property p_exec;
    fd_start |-> r.st[r.cur] == hr_pkg::HR_EXEC
                 && r.res[r.cur] == 3'h3;
  endproperty
  a_exec: assert property (p_exec)
    else $error("launched channel not executing");

  property p_seq_mode;
    ce && n.start |-> (r.seq_mode & ~(4'h1 << n.cur)) == 4'h0;
  endproperty
  a_seq_mode: assert property (p_seq_mode)
    else $error("launch during foreign shorthand sequence");

  property p_rsp;
    s_rd({8'h51, 8'h00}) |=> rdata[2:0] == $past(r.res[0])
                            && !rdata[5];
  endproperty
  a_rsp: assert property (p_rsp)
    else $error("response control byte wrong");
endmodule : hr_record_if
`default_nettype wire

// ==== hw/hr_cfg.svh ====
`ifndef HR_CFG_SVH
`define HR_CFG_SVH
// ==========================================
// record numbers
`define HR_REC_DIR   8'h94
`define HR_REC_FEAT  8'h95
`define HR_REC_VAR   8'h79
`define HR_REC_SET0  8'h83
`define HR_REC_SET3  8'h86
`define HR_REC_REQ0  8'h50
`define HR_REC_RSP3  8'h57
// ==========================================
// record lengths
`define HR_LEN_DIR   8'h11
`define HR_LEN_FEAT  8'h03
`define HR_LEN_VAR   8'h50
`define HR_LEN_SET   8'h08
`define HR_LEN_REC   8'hf0
// ==========================================
// directory contents
`define HR_REV_MAJ   8'h02
`define HR_REV_MIN   8'h00
`define HR_UNUSED    8'hff
`define HR_CLIENTS   8'h01
`define HR_CHANNELS  8'h04
`define HR_WR_OFS    8'h01
`define HR_DIR_SET   8'h09
`define HR_DIR_REQ   8'h0d
// ==========================================
// feature record and quality code
`define HR_FEAT0     8'h62
`define HR_FEAT1     8'h00
`define HR_QUAL_NONE 8'h37
// ==========================================
// preamble counts
`define HR_PRE_AUTO  8'h00
`define HR_PRE_MIN   8'h05
`define HR_PRE_MAX   8'h14
`define HR_PRE_CFG   8'hff
`define HR_PRE_DFLT  8'h05
// ==========================================
// control byte fields and result codes
`define HR_CTRL_RSVD 8'h9b
`define HR_CTRL_CMP  5
`define HR_CTRL_SEQ  6
`define HR_RES_IDLE  3'h0
`define HR_RES_WAIT  3'h2
`define HR_RES_EXEC  3'h3
`define HR_RES_ERR   3'h7
`endif

// ==== hw/hr_pkg.sv ====
package hr_pkg;
  typedef enum logic [3:0] {
    HR_IDLE = 4'h1,
    HR_WAIT = 4'h2,
    HR_EXEC = 4'h4,
    HR_DONE = 4'h8
  } hr_st_e;

  typedef struct packed {
    hr_st_e [3:0]          st;
    logic [3:0][2:0]       res;
    logic [3:0]            seq_mode;
    logic [3:0][7:0]       len;
    logic [3:0][7:0]       pre;
    logic [3:0][7:0]       ctrl;
    logic [3:0][7:0][7:0]  set;
    logic                  busy;
    logic [1:0]            cur;
    logic [7:0]            rdata;
    logic                  start;
    logic [7:0]            fd_pre;
    logic                  cmp;
    logic                  fd_seq;
    logic [7:0]            fd_len;
  } hr_state_s;
endpackage : hr_pkg

// ==== testbench/hr_fd_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ====================
// field device responder
module hr_fd_model (
  input  wire logic       core_clk,    // clock
  input  wire logic       rst,         // sync reset
  input  wire logic       fd_start,    // launch pulse
  input  wire logic [7:0] fd_rd_data,  // request byte
  input  wire logic [2:0] res_sel,     // result to return
  output logic      [7:0] fd_rd_addr,  // request byte addr
  output logic            fd_rsp_we,   // response write
  output logic      [7:0] fd_rsp_addr, // response offset
  output logic      [7:0] fd_rsp_data, // response byte
  output logic            fd_done,     // reply pulse
  output logic      [2:0] fd_result    // result code
);
  logic [3:0] cnt;
  logic       busy;

  always_ff @(posedge core_clk) begin
    fd_rsp_we <= 1'b0;
    fd_done   <= 1'b0;
    if (rst) begin
      {busy, cnt, fd_rd_addr, fd_rsp_addr} <= '0;
      {fd_rsp_data, fd_result}             <= '0;
    end else if (fd_start) begin
      busy       <= 1'b1;
      cnt        <= 4'hc;
      fd_rd_addr <= 8'h02;
    end else if (busy) begin
      cnt <= cnt - 4'h1;
      // echo first frame byte into response byte 2
      if (cnt == 4'h2) begin
        fd_rsp_we   <= 1'b1;
        fd_rsp_addr <= 8'h02;
        fd_rsp_data <= fd_rd_data;
      end
      if (cnt == 4'h0) begin
        busy        <= 1'b0;
        fd_done     <= 1'b1;
        fd_result   <= res_sel;
        fd_rsp_data <= ~fd_rsp_data;
      end
    end
  end
endmodule : hr_fd_model
`default_nettype wire

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "hr_cfg.svh"
module tb_top;
  logic        core_clk, rst, ce, wr, rd, param_reassign;
  logic        supply_ok, var_we, var_supplied, fd_start;
  logic        fd_compact, fd_seq_mode, fd_rsp_we, fd_done;
  logic [1:0]  var_ch, var_idx, fd_ch;
  logic [2:0]  fd_result, res_sel;
  logic [3:0]  hart_en;
  logic [7:0]  wdata, rdata, var_quality, fd_preamble, fd_len;
  logic [7:0]  fd_rd_addr, fd_rd_data, fd_rsp_addr, fd_rsp_data;
  logic [15:0] addr;
  logic [31:0] init_preamble, dev_preamble, var_value;
  int          miscompares, checks, cyc, starts;

  hr_record_if dut_u (
    .core_clk, .rst, .ce, .addr, .wdata, .wr, .rd, .rdata, .hart_en,
    .supply_ok, .param_reassign, .init_preamble, .dev_preamble, .var_we,
    .var_ch, .var_idx, .var_value, .var_quality, .var_supplied, .fd_start,
    .fd_ch, .fd_preamble, .fd_compact, .fd_seq_mode, .fd_len, .fd_rd_addr,
    .fd_rd_data, .fd_rsp_we, .fd_rsp_addr, .fd_rsp_data, .fd_done,
    .fd_result
  );
  hr_fd_model fd_u (
    .core_clk, .rst, .fd_start, .fd_rd_data, .res_sel, .fd_rd_addr,
    .fd_rsp_we, .fd_rsp_addr, .fd_rsp_data, .fd_done, .fd_result
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc++;
    if (fd_start === 1'b1) begin
      starts++;
    end
    if (cyc == 3000) begin
      miscompares++;
      end_of_test();
    end
  end

  // ====================
  // access tasks
  task automatic cmp(input string what, input logic [7:0] exp, got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s exp %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic bwr(input logic [7:0] rec, ofs, dat);
    addr  <= {rec, ofs};
    wdata <= dat;
    wr    <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
    @(posedge core_clk);
  endtask : bwr

  task automatic brd(input logic [7:0] rec, ofs, exp);
    addr <= {rec, ofs};
    rd   <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    @(posedge core_clk);
    cmp($sformatf("record %h", {rec, ofs}), exp, rdata);
  endtask : brd

  task automatic var_put(input logic sup);
    var_ch       <= 2'h1;
    var_idx      <= 2'h2;
    var_value    <= 32'h3f800000;
    var_quality  <= 8'h80;
    var_supplied <= sup;
    var_we       <= 1'b1;
    @(posedge core_clk);
    var_we <= 1'b0;
    @(posedge core_clk);
  endtask : var_put

  task automatic req_put(input logic [1:0] ch, input logic [7:0] ctl, pre);
    logic [7:0] r;
    r = `HR_REC_REQ0 + {5'h00, ch, 1'b0};
    bwr(r, 8'h01, pre);
    bwr(r, 8'h02, {6'h0c, ch});
    bwr(r, 8'h00, ctl);
  endtask : req_put

  task automatic wait_done();
    int i;
    i = 0;
    while (fd_done !== 1'b1 && i < 40) begin
      @(posedge core_clk);
      i++;
    end
    cmp("fd_done", 8'h01, {7'h00, fd_done});
  endtask : wait_done

  task automatic req_run(input logic [1:0] ch, input logic [7:0] pre, ctl);
    logic [7:0] r;
    logic [7:0] rsp;
    int         i;
    r   = `HR_REC_REQ0 + {5'h00, ch, 1'b1};
    rsp = {1'b0, ctl[6], 3'h0, 3'h3};
    i   = 0;
    while (fd_start !== 1'b1 && i < 20) begin
      @(posedge core_clk);
      i++;
    end
    cmp("fd_start", 8'h01, {7'h00, fd_start});
    cmp("fd_ch", {6'h00, ch}, {6'h00, fd_ch});
    cmp("fd_preamble", pre, fd_preamble);
    cmp("flags", 8'(ctl[6:5]), {6'h00, fd_seq_mode, fd_compact});
    cmp("fd_len", 8'h03, fd_len);
    brd(r, 8'h00, rsp);
    wait_done();
    rsp[2:0] = res_sel;
    brd(r, 8'h00, rsp);
    if (res_sel == 3'h4) begin
      brd(r, 8'h02, {6'h0c, ch});
    end
  endtask : req_run

  task automatic end_of_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  // ====================
  // test sequence
  initial begin : main
    logic [7:0] dir [17];
    logic [7:0] epre [4];
    logic [7:0] bad [5];
    int         n0;
    dir  = '{8'h02, 8'h00, 8'hff, 8'h01, 8'h04, 8'h01, 8'h95, 8'hff, 8'hff,
             8'h83, 8'h84, 8'h85, 8'h86, 8'h50, 8'h52, 8'h54, 8'h56};
    epre = '{8'h0a, 8'h14, 8'h05, 8'h08};
    bad  = '{8'h01, 8'h02, 8'h08, 8'h10, 8'h80};
    {rst, ce, hart_en, supply_ok} = {1'b1, 1'b1, 4'hf, 1'b0};
    {wr, rd, param_reassign, var_we, var_supplied} = 5'h00;
    {addr, wdata, var_ch, var_idx, var_quality, var_value} = '0;
    init_preamble = 32'h0c0b0a09;
    dev_preamble  = 32'h08030303;
    res_sel       = 3'h4;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    bwr(`HR_REC_DIR, 8'h00, 8'h55);
    for (int i = 0; i < 17; i++) begin
      brd(`HR_REC_DIR, 8'(i), dir[i]);
    end
    brd(`HR_REC_FEAT, 8'h00, 8'h62);
    brd(`HR_REC_FEAT, 8'h01, 8'h00);
    brd(`HR_REC_FEAT, 8'h02, 8'hf0);
    $display("test fixed records done");
    for (int i = 0; i < 80; i++) begin
      brd(`HR_REC_VAR, 8'(i), (i % 5 == 4) ? 8'h37 : 8'h00);
    end
    var_put(1'b1);
    for (int i = 0; i < 4; i++) begin
      brd(`HR_REC_VAR, 8'(30 + i), var_value[31 - 8 * i -: 8]);
    end
    brd(`HR_REC_VAR, 8'h22, 8'h80);
    hart_en <= 4'hd;
    brd(`HR_REC_VAR, 8'h1e, 8'h00);
    brd(`HR_REC_VAR, 8'h22, 8'h37);
    hart_en <= 4'hf;
    var_put(1'b0);
    brd(`HR_REC_VAR, 8'h22, 8'h37);
    $display("test variables done");
    bwr(`HR_REC_SET0, 8'h00, 8'h0a);
    brd(`HR_REC_SET0, 8'h00, 8'h05);
    supply_ok <= 1'b1;
    bwr(`HR_REC_SET0, 8'h00, 8'h0a);
    bwr(`HR_REC_SET0, 8'h00, 8'h03);
    brd(`HR_REC_SET0, 8'h00, 8'h0a);
    bwr(`HR_REC_SET0 + 8'h01, 8'h00, 8'hff);
    bwr(`HR_REC_SET0 + 8'h02, 8'h00, 8'h00);
    bwr(`HR_REC_SET3, 8'h00, 8'h00);
    brd(`HR_REC_SET0 + 8'h01, 8'h00, 8'hff);
    for (int c = 0; c < 4; c++) begin
      req_put(2'(c), 8'h00, 8'hff);
      req_run(2'(c), epre[c], 8'h00);
    end
    $display("test settings done");
    for (int r = 4; r < 8; r++) begin
      res_sel <= 3'(r);
      req_put(2'h0, 8'h20, 8'h07);
      req_run(2'h0, 8'h07, 8'h20);
    end
    res_sel <= 3'h4;
    req_put(2'h1, 8'h40, 8'h05);
    req_run(2'h1, 8'h05, 8'h40);
    req_put(2'h2, 8'h00, 8'h05);
    brd(`HR_REC_REQ0 + 8'h05, 8'h00, 8'h02);
    req_put(2'h1, 8'h00, 8'h05);
    req_run(2'h1, 8'h05, 8'h00);
    wait_done();
    brd(`HR_REC_REQ0 + 8'h05, 8'h00, 8'h04);
    $display("test requests done");
    n0 = starts;
    foreach (bad[k]) begin
      req_put(2'h0, bad[k], 8'h05);
      brd(`HR_REC_REQ0 + 8'h01, 8'h00, 8'h07);
    end
    req_put(2'h0, 8'h00, 8'h04);
    brd(`HR_REC_REQ0 + 8'h01, 8'h00, 8'h07);
    hart_en <= 4'h7;
    req_put(2'h3, 8'h00, 8'h05);
    brd(`HR_REC_REQ0 + 8'h07, 8'h00, 8'h07);
    cmp("launches", 8'h00, 8'(starts - n0));
    $display("test refusals done");
    param_reassign <= 1'b1;
    @(posedge core_clk);
    param_reassign <= 1'b0;
    brd(`HR_REC_SET0, 8'h00, 8'h09);
    brd(`HR_REC_SET3, 8'h00, 8'h0c);
    $display("test reassign done");
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
